//--- oad_pkg.sv
package oad_pkg;
    // Instruction classes, taken from bits 15:12.
    localparam logic [3:0] CLS_NOP = 4'h0;
    localparam logic [3:0] CLS_LDW = 4'h1;
    localparam logic [3:0] CLS_LDB = 4'h2;
    localparam logic [3:0] CLS_IMMS = 4'h3;
    localparam logic [3:0] CLS_IMML = 4'h4;
    localparam logic [3:0] CLS_FLAG = 4'h8;
    localparam logic [3:0] CLS_TBL = 4'h9;
    localparam logic [3:0] CLS_ROUNDING_MULTIPLY = 4'ha;
    // Field positions.
    localparam int NEXTA_LSB = 10;
    localparam int APSEL_LSB = 8;
    localparam int SHORT_BIT = 7;
    localparam int IND_BIT = 6;
    localparam int RX_LSB = 2;
    // Pre-modify codes.
    localparam logic [1:0] NA_NONE = 2'h0;
    localparam logic [1:0] NA_INC = 2'h1;
    localparam logic [1:0] NA_DEC = 2'h2;
    localparam logic [1:0] NA_STR = 2'h3;
    // Post-modify codes.
    localparam logic [1:0] PM_NONE = 2'h0;
    localparam logic [1:0] PM_INC = 2'h1;
    localparam logic [1:0] PM_DEC = 2'h2;
    localparam logic [1:0] PM_IDX = 2'h3;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [2:0] IDX_REG = 3'h5;
    localparam logic [2:0] PAGE_REG = 3'h6;
    localparam logic [31:0] ROUND_HALF = 32'h0000_8000;
    // Register map, byte addresses.
    localparam logic [7:0] OFF_AREG0 = 8'h00;
    localparam logic [7:0] OFF_APS = 8'h20;
    localparam logic [7:0] OFF_MR = 8'h24;
    localparam logic [7:0] OFF_PH = 8'h28;
    localparam logic [7:0] OFF_STATUS = 8'h2c;
    // Reset values.
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [4:0] RST_AP = 5'h00;

    typedef enum logic [1:0] {
        S_FETCH = 2'b00,
        S_WORD2 = 2'b01,
        S_PMRD = 2'b10,
        S_MRD = 2'b11
    } oad_state_t;

    function automatic logic oad_has_next(input logic [3:0] cls);
        oad_has_next = (cls == CLS_LDW) || (cls == CLS_LDB) || (cls == CLS_IMMS)
            || (cls == CLS_IMML);
    endfunction : oad_has_next

    function automatic logic [15:0] oad_step(input logic [3:0] cls);
        oad_step = (cls == CLS_LDB) ? STEP_BYTE : STEP_WORD;
    endfunction : oad_step
endpackage : oad_pkg

//--- oad_page_addr.sv
`timescale 1ns/1ns
module oad_page_addr (
    input wire logic [15:0] page_in,
    input wire logic [6:0] field_in,
    output logic [15:0] flag_addr_out,
    output logic [15:0] short_addr_out
);
    wire [15:0] flag_off = {10'h000, field_in[6:1]};

    // Global flags count from location zero, relative ones from the page base.
    assign flag_addr_out = field_in[0] ? page_in + flag_off : flag_off;
    assign short_addr_out = page_in + {9'h000, field_in};
endmodule : oad_page_addr

//--- oad_round_mul.sv
`timescale 1ns/1ns
module oad_round_mul (
    input wire logic [15:0] mr_in,
    input wire logic [15:0] opnd_in,
    output logic [15:0] ph_out
);
    wire [31:0] prod = mr_in * opnd_in;
    wire [31:0] rnd = prod + oad_pkg::ROUND_HALF;

    // Only the rounded upper half survives.
    assign ph_out = rnd[31:16];
endmodule : oad_round_mul

//--- oad_operand_decode.sv
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module oad_operand_decode (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_in,
    output logic instr_ready_out,
    output logic dm_req_out,
    output logic dm_we_out,
    output logic [15:0] dm_addr_out,
    output logic [15:0] dm_wdata_out,
    input wire logic [15:0] dm_rdata_in,
    output logic pm_req_out,
    output logic [15:0] pm_addr_out,
    input wire logic [15:0] pm_rdata_in,
    output logic [4:0] acc_index_out,
    input wire logic [15:0] acc_value_in,
    output logic [15:0] imm_out,
    output logic imm_valid_out,
    output logic [15:0] flag_addr_out,
    output logic flag_valid_out,
    output logic string_mode_out,
    output logic op_done_out
);
    oad_pkg::oad_state_t st_q, st_d;
    logic [7:0][15:0] areg_q;
    logic [3:0][4:0] ap_q;
    logic [15:0] mr_q, ph_q, dest_q;
    logic [3:0] cls_q;
    logic rdy_q, prdy_q, perr_q;
    logic [31:0] prd_q;

    // APB decode, zero wait states: pready rises in every access phase.
    wire apb_setup = psel_in & ~penable_in;
    wire apb_wr = psel_in & penable_in & prdy_q & pwrite_in & ~perr_q;
    wire aligned = paddr_in[1:0] == 2'h0;
    wire mapped = aligned & (paddr_in <= oad_pkg::OFF_STATUS);
    wire is_areg = paddr_in < oad_pkg::OFF_APS;
    wire [2:0] widx = paddr_in[4:2];
    wire [31:0] rd_mux =
        !mapped ? 32'h0 :
        is_areg ? {16'h0, areg_q[widx]} :
        paddr_in == oad_pkg::OFF_APS ?
            {3'h0, ap_q[3], 3'h0, ap_q[2], 3'h0, ap_q[1], 3'h0, ap_q[0]} :
        paddr_in == oad_pkg::OFF_MR ? {16'h0, mr_q} :
        paddr_in == oad_pkg::OFF_PH ? {16'h0, ph_q} :
        {30'h0, st_q};

    // Instruction field decode.
    wire fetch = (st_q == oad_pkg::S_FETCH) & rdy_q & instr_valid_in;
    wire word2 = (st_q == oad_pkg::S_WORD2) & rdy_q & instr_valid_in;
    wire [3:0] cls = instr_in[15:12];
    wire [1:0] nexta = instr_in[oad_pkg::NEXTA_LSB +: 2];
    wire [1:0] apsel = instr_in[oad_pkg::APSEL_LSB +: 2];
    wire has_next = oad_pkg::oad_has_next(cls);
    wire [4:0] ap_cur = ap_q[apsel];
    wire [4:0] ap_new = !has_next ? ap_cur :
        nexta == oad_pkg::NA_INC ? ap_cur + 5'h01 :
        nexta == oad_pkg::NA_DEC ? ap_cur - 5'h01 : ap_cur;
    wire str_hit = has_next & (nexta == oad_pkg::NA_STR);
    wire is_short = instr_in[oad_pkg::SHORT_BIT];
    wire is_ind = ~is_short & instr_in[oad_pkg::IND_BIT];
    wire is_direct = ~is_short & ~instr_in[oad_pkg::IND_BIT];
    wire [2:0] rx = instr_in[oad_pkg::RX_LSB +: 3];
    wire [1:0] pm = instr_in[1:0];
    wire [15:0] step = oad_pkg::oad_step(cls);
    wire [15:0] areg_post =
        pm == oad_pkg::PM_INC ? areg_q[rx] + step :
        pm == oad_pkg::PM_DEC ? areg_q[rx] - step :
        pm == oad_pkg::PM_IDX ? areg_q[rx] + areg_q[oad_pkg::IDX_REG] : areg_q[rx];
    wire adrs_cls = (cls == oad_pkg::CLS_LDW) | (cls == oad_pkg::CLS_LDB)
        | (cls == oad_pkg::CLS_ROUNDING_MULTIPLY);
    wire [15:0] flag_addr, short_addr, ph_new;
    wire [15:0] ea_now = is_short ? short_addr : areg_q[rx];
    wire post_wr = fetch & adrs_cls & is_ind;

    oad_page_addr u_page (
        .page_in(areg_q[oad_pkg::PAGE_REG]),
        .field_in(instr_in[6:0]),
        .flag_addr_out(flag_addr),
        .short_addr_out(short_addr)
    );

    oad_round_mul u_mul (
        .mr_in(mr_q),
        .opnd_in(dm_rdata_in),
        .ph_out(ph_new)
    );

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            oad_pkg::S_FETCH: begin
                if (fetch && (cls == oad_pkg::CLS_IMML || cls == oad_pkg::CLS_TBL
                    || (adrs_cls && is_direct))) begin
                    st_d = oad_pkg::S_WORD2;
                end else if (fetch && cls == oad_pkg::CLS_ROUNDING_MULTIPLY) begin
                    st_d = oad_pkg::S_MRD;
                end
            end
            oad_pkg::S_WORD2: begin
                if (word2) begin
                    st_d = cls_q == oad_pkg::CLS_TBL ? oad_pkg::S_PMRD :
                        cls_q == oad_pkg::CLS_ROUNDING_MULTIPLY ? oad_pkg::S_MRD : oad_pkg::S_FETCH;
                end
            end
            oad_pkg::S_PMRD: st_d = oad_pkg::S_FETCH;
            oad_pkg::S_MRD: st_d = oad_pkg::S_FETCH;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdy_q <= 1'b0;
            perr_q <= 1'b0;
            prd_q <= 32'h0;
        end else begin
            prdy_q <= apb_setup;
            perr_q <= apb_setup & ~mapped;
            prd_q <= apb_setup ? rd_mux : 32'h0;
        end
    end

    // Software writes override a same-cycle update from an instruction.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            areg_q <= '0;
            ap_q <= '0;
            mr_q <= oad_pkg::RST_WORD;
        end else begin
            if (fetch) begin
                ap_q[apsel] <= ap_new;
            end
            if (post_wr) begin
                areg_q[rx] <= areg_post;
            end
            if (apb_wr && is_areg) begin
                areg_q[widx] <= pwdata_in[15:0];
            end
            if (apb_wr && paddr_in == oad_pkg::OFF_APS) begin
                ap_q <= {pwdata_in[28:24], pwdata_in[20:16], pwdata_in[12:8], pwdata_in[4:0]};
            end
            if (apb_wr && paddr_in == oad_pkg::OFF_MR) begin
                mr_q <= pwdata_in[15:0];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q <= oad_pkg::S_FETCH;
            rdy_q <= 1'b1;
            cls_q <= oad_pkg::CLS_NOP;
            dest_q <= oad_pkg::RST_WORD;
            ph_q <= oad_pkg::RST_WORD;
            dm_req_out <= 1'b0;
            dm_we_out <= 1'b0;
            dm_addr_out <= oad_pkg::RST_WORD;
            dm_wdata_out <= oad_pkg::RST_WORD;
            pm_req_out <= 1'b0;
            pm_addr_out <= oad_pkg::RST_WORD;
            acc_index_out <= oad_pkg::RST_AP;
            imm_out <= oad_pkg::RST_WORD;
            imm_valid_out <= 1'b0;
            flag_addr_out <= oad_pkg::RST_WORD;
            flag_valid_out <= 1'b0;
            string_mode_out <= 1'b0;
            op_done_out <= 1'b0;
        end else begin
            st_q <= st_d;
            rdy_q <= (st_d == oad_pkg::S_FETCH) || (st_d == oad_pkg::S_WORD2);
            dm_req_out <= 1'b0;
            dm_we_out <= 1'b0;
            pm_req_out <= 1'b0;
            imm_valid_out <= 1'b0;
            flag_valid_out <= 1'b0;
            string_mode_out <= 1'b0;
            op_done_out <= 1'b0;
            if (fetch) begin
                cls_q <= cls;
                acc_index_out <= {apsel, 3'h0} + ap_new;
                string_mode_out <= str_hit;
                if (adrs_cls && !is_direct) begin
                    dm_req_out <= 1'b1;
                    dm_addr_out <= ea_now;
                    op_done_out <= cls != oad_pkg::CLS_ROUNDING_MULTIPLY;
                end else if (cls == oad_pkg::CLS_IMMS) begin
                    imm_out <= {8'h00, instr_in[7:0]};
                    imm_valid_out <= 1'b1;
                    op_done_out <= 1'b1;
                end else if (cls == oad_pkg::CLS_FLAG) begin
                    flag_addr_out <= flag_addr;
                    flag_valid_out <= 1'b1;
                    op_done_out <= 1'b1;
                end else if (st_d == oad_pkg::S_FETCH) begin
                    op_done_out <= 1'b1;
                end
            end
            if (word2) begin
                if (cls_q == oad_pkg::CLS_IMML) begin
                    imm_out <= instr_in;
                    imm_valid_out <= 1'b1;
                    op_done_out <= 1'b1;
                end else if (cls_q == oad_pkg::CLS_TBL) begin
                    dest_q <= instr_in;
                    pm_req_out <= 1'b1;
                    pm_addr_out <= acc_value_in;
                end else begin
                    dm_req_out <= 1'b1;
                    dm_addr_out <= instr_in;
                    op_done_out <= cls_q != oad_pkg::CLS_ROUNDING_MULTIPLY;
                end
            end
            if (st_q == oad_pkg::S_PMRD) begin
                dm_req_out <= 1'b1;
                dm_we_out <= 1'b1;
                dm_addr_out <= dest_q;
                dm_wdata_out <= pm_rdata_in;
                op_done_out <= 1'b1;
            end
            if (st_q == oad_pkg::S_MRD) begin
                ph_q <= ph_new;
                op_done_out <= 1'b1;
            end
        end
    end

    always_comb begin
        prdata_out = prd_q;
        pready_out = prdy_q;
        pslverr_out = perr_q;
        instr_ready_out = rdy_q;
    end

    property p_pre_inc;
        @(posedge clk_in) disable iff (!rstn_in)
        fetch && has_next && nexta == oad_pkg::NA_INC && !apb_wr
            |=> ap_q[$past(apsel)] == $past(ap_cur) + 5'h01;
    endproperty
    a_pre_inc: assert property (p_pre_inc) else $error("pre-increment missing");
    property p_pre_dec;
        @(posedge clk_in) disable iff (!rstn_in)
        fetch && has_next && nexta == oad_pkg::NA_DEC && !apb_wr
            |=> ap_q[$past(apsel)] == $past(ap_cur) - 5'h01;
    endproperty
    a_pre_dec: assert property (p_pre_dec) else $error("pre-decrement missing");
    property p_no_field;
        @(posedge clk_in) disable iff (!rstn_in)
        fetch && !has_next && !apb_wr |=> $stable(ap_q);
    endproperty
    a_no_field: assert property (p_no_field) else $error("pointer changed");
    property p_string;
        @(posedge clk_in) disable iff (!rstn_in)
        fetch && str_hit && !apb_wr |=> string_mode_out && $stable(ap_q);
    endproperty
    a_string: assert property (p_string) else $error("string mode wrong");
    property p_flag;
        @(posedge clk_in) disable iff (!rstn_in)
        fetch && cls == oad_pkg::CLS_FLAG |=> flag_valid_out && flag_addr_out ==
            ($past(instr_in[0]) ? $past(areg_q[oad_pkg::PAGE_REG]) : 16'h0)
            + {10'h000, $past(instr_in[6:1])};
    endproperty
    a_flag: assert property (p_flag) else $error("flag address wrong");
    property p_imm_one;
        @(posedge clk_in) disable iff (!rstn_in)
        fetch && cls == oad_pkg::CLS_IMMS |=> imm_valid_out && op_done_out
            ##1 (!op_done_out || $past(fetch));
    endproperty
    a_imm_one: assert property (p_imm_one) else $error("short immediate late");
    property p_direct;
        @(posedge clk_in) disable iff (!rstn_in)
        word2 && cls_q != oad_pkg::CLS_TBL && cls_q != oad_pkg::CLS_IMML
            |=> dm_req_out && dm_addr_out == $past(instr_in);
    endproperty
    a_direct: assert property (p_direct) else $error("direct address altered");
    property p_short;
        @(posedge clk_in) disable iff (!rstn_in)
        fetch && adrs_cls && is_short |=> dm_addr_out ==
            $past(areg_q[oad_pkg::PAGE_REG]) + {9'h000, $past(instr_in[6:0])};
    endproperty
    a_short: assert property (p_short) else $error("short relative wrong");
    property p_post;
        @(posedge clk_in) disable iff (!rstn_in)
        post_wr && pm == oad_pkg::PM_INC && !apb_wr
            |=> areg_q[$past(rx)] == $past(areg_q[rx]) + $past(step);
    endproperty
    a_post: assert property (p_post) else $error("post step wrong");
    property p_table;
        @(posedge clk_in) disable iff (!rstn_in)
        word2 && cls_q == oad_pkg::CLS_TBL |=> pm_req_out ##1
            dm_we_out && dm_wdata_out == $past(pm_rdata_in) && dm_addr_out == $past(dest_q);
    endproperty
    a_table: assert property (p_table) else $error("table lookup wrong");
    property p_rounding_multiply;
        @(posedge clk_in) disable iff (!rstn_in)
        st_q == oad_pkg::S_MRD |=> ph_q == (($past(mr_q) * $past(dm_rdata_in)
            + oad_pkg::ROUND_HALF) >> 16);
    endproperty
    a_rounding_multiply: assert property (p_rounding_multiply) else $error("product high wrong");
    c_imm_long: cover property (@(posedge clk_in) disable iff (!rstn_in)
        word2 && cls_q == oad_pkg::CLS_IMML);
    c_table: cover property (@(posedge clk_in) disable iff (!rstn_in) st_q == oad_pkg::S_PMRD);
    c_rounding_multiply: cover property (@(posedge clk_in) disable iff (!rstn_in) st_q == oad_pkg::S_MRD);
endmodule : oad_operand_decode

//--- oad_mem_model.sv
`timescale 1ns/1ns
module oad_mem_model (
    input wire logic clk_in,
    input wire logic dm_req_in,
    input wire logic dm_we_in,
    input wire logic [15:0] dm_addr_in,
    input wire logic [15:0] dm_wdata_in,
    output logic [15:0] dm_rdata_out,
    input wire logic pm_req_in,
    input wire logic [15:0] pm_addr_in,
    output logic [15:0] pm_rdata_out,
    input wire logic [4:0] acc_index_in,
    output logic [15:0] acc_value_out
);
    logic [15:0] dmem [256];
    logic [15:0] dm_idle, pm_idle;
    // Accumulator contents follow a fixed pattern of the index.
    assign acc_value_out = 16'h0123 + {3'h0, acc_index_in, 8'h00};
    // Read data stands in the request cycle, since the decoder takes it at the next edge.
    assign dm_rdata_out = (dm_req_in && !dm_we_in) ? dmem[dm_addr_in[8:1]] : dm_idle;
    assign pm_rdata_out = pm_req_in ? (pm_addr_in ^ 16'h5a5a) : pm_idle;
    initial begin
        dm_idle = 16'h0000;
        pm_idle = 16'h0000;
        for (int i = 0; i < 256; i++) begin
            dmem[i] = 16'h1001 + 16'(i) * 16'h0111;
        end
    end
    // Words sit at even byte addresses; outside a request the read lines wander.
    always @(posedge clk_in) begin
        if (dm_req_in && dm_we_in) begin
            dmem[dm_addr_in[8:1]] <= dm_wdata_in;
        end
        dm_idle <= ~dm_idle;
        pm_idle <= ~pm_idle;
    end
endmodule : oad_mem_model

//--- tb.sv
`timescale 1ns/1ns
module tb;
    logic clk_in, rstn_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd, aps, mr, ph;
    logic instr_valid_in, instr_ready_out, dm_req_out, dm_we_out, pm_req_out, er;
    logic [15:0] instr_in, dm_addr_out, dm_wdata_out, dm_rdata_in, pm_addr_out, pm_rdata_in;
    logic [4:0] acc_index_out;
    logic [15:0] acc_value_in, imm_out, flag_addr_out, s_imm, s_flag, s_dma, s_dmw, s_pma;
    logic imm_valid_out, flag_valid_out, string_mode_out, op_done_out, s_iv, s_fv, s_str, s_we;
    int err_total, check_count, s_dm, s_el;
    int cyc = 0;

    oad_operand_decode oad_operand_decode_i (.clk_in(clk_in), .rstn_in(rstn_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
        .instr_ready_out(instr_ready_out), .dm_req_out(dm_req_out), .dm_we_out(dm_we_out),
        .dm_addr_out(dm_addr_out), .dm_wdata_out(dm_wdata_out), .dm_rdata_in(dm_rdata_in),
        .pm_req_out(pm_req_out), .pm_addr_out(pm_addr_out), .pm_rdata_in(pm_rdata_in),
        .acc_index_out(acc_index_out), .acc_value_in(acc_value_in), .imm_out(imm_out),
        .imm_valid_out(imm_valid_out), .flag_addr_out(flag_addr_out),
        .flag_valid_out(flag_valid_out), .string_mode_out(string_mode_out),
        .op_done_out(op_done_out));
    oad_mem_model oad_mem_model_i (.clk_in(clk_in), .dm_req_in(dm_req_out),
        .dm_we_in(dm_we_out), .dm_addr_in(dm_addr_out), .dm_wdata_in(dm_wdata_out),
        .dm_rdata_out(dm_rdata_in), .pm_req_in(pm_req_out), .pm_addr_in(pm_addr_out),
        .pm_rdata_out(pm_rdata_in), .acc_index_in(acc_index_out), .acc_value_out(acc_value_in));

    initial begin
        clk_in = 1'h0;
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in) cyc <= cyc + 1;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        print_verdict();
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'h1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'h1;
        do @(posedge clk_in); while (pready_out !== 1'h1);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
    endtask : apb

    function automatic logic [15:0] w(input logic [3:0] c, input logic [1:0] na,
                                      input logic [7:0] f);
        return {c, na, 2'h0, f};
    endfunction : w

    function automatic logic [31:0] rounding_multiply(input logic [15:0] m, input logic [15:0] o);
        logic [31:0] p;
        p = 32'(m) * 32'(o) + 32'h0000_8000;
        return {16'h0000, p[31:16]};
    endfunction : rounding_multiply

    // Sends one or two words, then gathers every pulse after the last word is taken until the instruction finishes.
    task automatic op(input logic [15:0] w1, input logic [15:0] w2, input logic two);
        int t0;
        s_iv = 1'h0;
        s_fv = 1'h0;
        s_str = 1'h0;
        s_dm = 0;
        {s_we, s_dma, s_dmw, s_pma} = 'x;
        @(posedge clk_in);
        instr_valid_in <= 1'h1;
        instr_in <= w1;
        for (int k = 0; k < 2; k++) begin
            do @(posedge clk_in); while (instr_ready_out !== 1'h1);
            if (k == 0) t0 = cyc;
            if (two !== 1'h1) break;
            instr_in <= w2;
        end
        instr_valid_in <= 1'h0;
        forever begin
            #1;
            if (imm_valid_out === 1'h1) {s_iv, s_imm} = {1'h1, imm_out};
            if (flag_valid_out === 1'h1) {s_fv, s_flag} = {1'h1, flag_addr_out};
            if (string_mode_out === 1'h1) s_str = 1'h1;
            if (pm_req_out === 1'h1) s_pma = pm_addr_out;
            if (dm_req_out === 1'h1) begin
                s_dm++;
                {s_we, s_dma, s_dmw} = {dm_we_out, dm_addr_out, dm_wdata_out};
            end
            if (op_done_out === 1'h1) break;
            @(posedge clk_in);
        end
        s_el = cyc - t0;
    endtask : op

    initial begin
        logic [15:0] pg, r2, v, a, st;
        {psel_in, penable_in, pwrite_in, instr_valid_in, rstn_in} = 5'h00;
        {paddr_in, pwdata_in, instr_in} = 56'h0;
        void'($urandom(4));
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'h1;
        chk(instr_ready_out, 1'h1);
        for (int i = 0; i < 13; i++) begin
            apb(1'h0, 8'(i * 4), 32'h0);
            chk(rd, 32'h0);
            chk(er, i == 12);
        end
        $display("test reset_map done");
        aps = ($urandom & 32'h1f1f_1f07) | 32'h0000_0008;
        apb(1'h1, oad_pkg::OFF_APS, aps);
        for (int n = 0; n < 8; n++) begin
            v = 16'($urandom);
            op(w(oad_pkg::CLS_IMMS, 2'(n), v[7:0]), 16'h0, 1'h0);
            if (n % 4 == 1) aps[4:0] = aps[4:0] + 5'h01;
            if (n % 4 == 2) aps[4:0] = aps[4:0] - 5'h01;
            chk({s_iv, s_imm}, {1'h1, 8'h00, v[7:0]});
            chk(s_el, 1);
            chk(acc_index_out, aps[4:0]);
            chk(s_str, n % 4 == 3);
            apb(1'h0, oad_pkg::OFF_APS, 32'h0);
            chk(rd, aps);
        end
        for (int n = 0; n < 4; n++) begin
            v = (n == 0) ? 16'hffff : 16'($urandom);
            op(w(oad_pkg::CLS_IMML, 2'h0, 8'h00), v, 1'h1);
            chk({s_iv, s_imm}, {1'h1, v});
            chk(s_el, 2);
        end
        $display("test premodify_imm done");
        pg = 16'($urandom);
        apb(1'h1, 8'h18, {16'h0, pg});
        for (int n = 0; n < 8; n++) begin
            v = (n < 2) ? 16'h007f - 16'(n) : 16'($urandom);
            op(w(oad_pkg::CLS_FLAG, 2'(n), {1'h0, v[6:0]}), 16'h0, 1'h0);
            chk(s_fv, 1'h1);
            chk(s_flag, v[0] ? 16'(pg + v[6:1]) : {10'h0, v[6:1]});
        end
        op(w(oad_pkg::CLS_NOP, 2'h1, 8'h00), 16'h0, 1'h0);
        chk(s_el, 1);
        apb(1'h0, 8'h18, 32'h0);
        chk(rd, {16'h0, pg});
        apb(1'h0, oad_pkg::OFF_APS, 32'h0);
        chk(rd, aps);
        $display("test flag done");
        for (int n = 0; n < 6; n++) begin
            a = 16'($urandom);
            op(w(n[0] ? oad_pkg::CLS_LDB : oad_pkg::CLS_LDW, 2'h0, 8'h00), a, 1'h1);
            chk({s_dm[14:0], s_we, s_dma}, {15'h1, 1'h0, a});
            chk(s_el, 2);
            v = 16'($urandom);
            op(w(oad_pkg::CLS_LDW, 2'h0, {1'h1, v[6:0]}), 16'h0, 1'h0);
            chk(s_dma, 16'(pg + v[6:0]));
        end
        r2 = 16'($urandom);
        apb(1'h1, 8'h08, {16'h0, r2});
        apb(1'h1, 8'h14, 32'h0000_0036);
        for (int n = 0; n < 8; n++) begin
            st = (n > 3) ? 16'h0001 : 16'h0002;
            op(w(n > 3 ? oad_pkg::CLS_LDB : oad_pkg::CLS_LDW, 2'h0, {6'h12, 2'(n)}), 16'h0, 1'h0);
            chk(s_dma, r2);
            if (n % 4 == 1) r2 = r2 + st;
            if (n % 4 == 2) r2 = r2 - st;
            if (n % 4 == 3) r2 = r2 + 16'h0036;
            apb(1'h0, 8'h08, 32'h0);
            chk(rd, {16'h0, r2});
        end
        $display("test data_address done");
        for (int n = 0; n < 3; n++) begin
            a = 16'($urandom) & 16'h01fe | 16'h0100;
            op(w(oad_pkg::CLS_TBL, 2'h0, 8'h00), a, 1'h1);
            v = 16'h0123 + {3'h0, aps[4:0], 8'h00};
            chk(s_pma, v);
            chk(s_we, 1'h1);
            chk({s_dma, s_dmw}, {a, v ^ 16'h5a5a});
            chk(s_el, 3);
        end
        for (int n = 0; n < 4; n++) begin
            mr = (n == 0) ? 32'h0000_1a15 : $urandom & 32'h0000_ffff;
            a = (n == 0) ? 16'h0000 : 16'($urandom) & 16'h00fe;
            apb(1'h1, oad_pkg::OFF_MR, mr);
            op(w(oad_pkg::CLS_ROUNDING_MULTIPLY, 2'h0, 8'h00), a, 1'h1);
            chk(s_el, 3);
            ph = rounding_multiply(mr[15:0], 16'h1001 + 16'(a[8:1]) * 16'h0111);
            apb(1'h0, oad_pkg::OFF_PH, 32'h0);
            chk(rd, ph);
        end
        apb(1'h1, oad_pkg::OFF_PH, 32'h0000_1234);
        apb(1'h0, oad_pkg::OFF_PH, 32'h0);
        chk(rd, ph);
        apb(1'h0, oad_pkg::OFF_STATUS, 32'h0);
        chk(rd, 32'h0);
        $display("test table_multiply done");
        print_verdict();
    end
endmodule : tb
